// >>> shared/wbsr_regs.vh
`ifndef WBSR_REGS_VH
`define WBSR_REGS_VH

// register addresses on the 7-bit serial register port
`define WBSR_ADDR_LIN_FAULT 7'h45
`define WBSR_ADDR_WAKE_MAIN 7'h46
`define WBSR_ADDR_WAKE_GPIO 7'h47
`define WBSR_ADDR_LEVELS 7'h48

// reset values
`define WBSR_RST_LIN_FAULT 8'h00
`define WBSR_RST_WAKE_MAIN 8'h00
`define WBSR_RST_WAKE_GPIO 8'h00
`define WBSR_RST_LEVELS 8'h00

// implemented bits, all others read zero
`define WBSR_MASK_LIN_FAULT 8'h06
`define WBSR_MASK_WAKE_MAIN 8'hF7
`define WBSR_MASK_WAKE_GPIO 8'h30
`define WBSR_MASK_LEVELS 8'hF7

// field positions
`define WBSR_FAULT_LO 1
`define WBSR_FAULT_HI 2
`define WBSR_WK_LIN2 7
`define WBSR_WK_LIN1 6
`define WBSR_WK_CAN 5
`define WBSR_WK_TIMER 4
`define WBSR_WK_IN3 2
`define WBSR_WK_IN2 1
`define WBSR_WK_IN1 0
`define WBSR_WK_GPIO2 5
`define WBSR_WK_GPIO1 4
`define WBSR_LVL_DEV 7
`define WBSR_LVL_INTERRUPT_PULLUP_CONFIG_STATUS 6
`define WBSR_LVL_GPIO2 5
`define WBSR_LVL_GPIO1 4

// fault codes
`define WBSR_CODE_NONE 2'h0
`define WBSR_CODE_TSD 2'h1
`define WBSR_CODE_TXD_DOM 2'h2
`define WBSR_CODE_BUS_DOM 2'h3

// timing
`define WBSR_CLK_KHZ 20000
`define WBSR_DOM_TIMEOUT_MS 20
`define WBSR_DOM_TIMEOUT_CYC (`WBSR_DOM_TIMEOUT_MS * `WBSR_CLK_KHZ)
`define WBSR_TX_EN_TIME_US 10
`define WBSR_TX_EN_CYC (`WBSR_TX_EN_TIME_US * `WBSR_CLK_KHZ / 1000)

`endif

// >>> logic/wbsr_lin_fault.v
`timescale 1ns/1ps
`include "wbsr_regs.vh"

module wbsr_lin_fault #(
  parameter CNT_W = 20,
  parameter [CNT_W-1:0] DOM_TIMEOUT = `WBSR_DOM_TIMEOUT_CYC,
  parameter [CNT_W-1:0] TX_EN_TIME = `WBSR_TX_EN_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // transceiver status
  input wire trx_active,
  input wire tx_in,
  input wire bus_recessive,
  input wire thermal_shutdown,
  input wire supply_ok,
  // fault result
  output reg fault_event,
  output reg [1:0] fault_code,
  output reg tx_enable
);

  reg [CNT_W-1:0] txd_cnt;
  reg [CNT_W-1:0] bus_cnt;
  reg [CNT_W-1:0] en_cnt;
  reg second_lin_tx_stuck_dominant;
  reg second_lin_bus_stuck_dominant;
  reg tsd_seen;
  wire txd_hit;
  wire bus_hit;
  wire tsd_hit;
  wire any_fault;

  assign txd_hit = trx_active && !tx_in && (txd_cnt == DOM_TIMEOUT) && !second_lin_tx_stuck_dominant;
  assign bus_hit = trx_active && !bus_recessive && (bus_cnt == DOM_TIMEOUT) && !second_lin_bus_stuck_dominant;
  assign tsd_hit = thermal_shutdown && !tsd_seen;
  assign any_fault = second_lin_tx_stuck_dominant || second_lin_bus_stuck_dominant || thermal_shutdown
    || !supply_ok;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      txd_cnt <= {CNT_W{1'b0}};
      bus_cnt <= {CNT_W{1'b0}};
      en_cnt <= {CNT_W{1'b0}};
      second_lin_tx_stuck_dominant <= 1'b0;
      second_lin_bus_stuck_dominant <= 1'b0;
      tsd_seen <= 1'b0;
      fault_event <= 1'b0;
      fault_code <= `WBSR_CODE_NONE;
      tx_enable <= 1'b0;
    end else begin
      // dominant timers count up to the timeout and hold there
      if (!trx_active || tx_in)
        txd_cnt <= {CNT_W{1'b0}};
      else if (txd_cnt != DOM_TIMEOUT)
        txd_cnt <= txd_cnt + 1'b1;
      if (!trx_active || bus_recessive)
        bus_cnt <= {CNT_W{1'b0}};
      else if (bus_cnt != DOM_TIMEOUT)
        bus_cnt <= bus_cnt + 1'b1;
      // recovery on txd high or transceiver wake-capable/off
      if (tx_in || !trx_active)
        second_lin_tx_stuck_dominant <= 1'b0;
      else if (txd_hit)
        second_lin_tx_stuck_dominant <= 1'b1;
      // recovery on recessive bus or transceiver wake-capable/off
      if (bus_recessive || !trx_active)
        second_lin_bus_stuck_dominant <= 1'b0;
      else if (bus_hit)
        second_lin_bus_stuck_dominant <= 1'b1;
      tsd_seen <= thermal_shutdown;
      fault_event <= bus_hit || txd_hit || tsd_hit;
      if (bus_hit)
        fault_code <= `WBSR_CODE_BUS_DOM;
      else if (txd_hit)
        fault_code <= `WBSR_CODE_TXD_DOM;
      else if (tsd_hit)
        fault_code <= `WBSR_CODE_TSD;
      // undervoltage lifts with the comparator, then txd must stay high
      if (any_fault || !tx_in || !trx_active) begin
        en_cnt <= {CNT_W{1'b0}};
        if (any_fault || !trx_active)
          tx_enable <= 1'b0;
      end else if (en_cnt != TX_EN_TIME) begin
        en_cnt <= en_cnt + 1'b1;
      end else begin
        tx_enable <= 1'b1;
      end
    end
  end

endmodule // wbsr_lin_fault

// >>> logic/wbsr_top.v
`timescale 1ns/1ps
`include "wbsr_regs.vh"

// Behaviour
// - second LIN fault code at bits 2:1: 00 none, 01 thermal, 10 txd dominant >20ms.
// - code 11 is loaded when the bus stays dominant over 20ms.
// - reserved bits in all four registers always read zero.
// - txd timeout recovers on txd high or transceiver wake-capable/off.
// - bus timeout recovers on recessive bus or transceiver wake-capable/off.
// - undervoltage recovers as soon as the supply comparator reports good supply.
// - transmission resumes only after txd stays high for the enable time.
// - one latched wake flag per source at the fixed bit positions.
// - wake out of fail-safe also sets the responsible source flag.
// - level bit 7 shows development mode selected by the test pin.
// - level bit 6 shows the interrupt pin pull-up configuration strap.
// - level bits show wake inputs 1..3 at 0..2 and gpios at 4/5.
// - gpio levels refresh in normal and stop modes for wake/switch configs.
// - in cyclic sense, wake input levels hold samples, rewritten per sample.
// - gpio levels are never taken from cyclic samples.
// - a gpio-selected pin shows its level even when used as a switch.
// - fault register resets to zero; restart keeps the code only.

module wbsr_top #(
  parameter CNT_W = 20,
  parameter [CNT_W-1:0] DOM_TIMEOUT = `WBSR_DOM_TIMEOUT_CYC,
  parameter [CNT_W-1:0] TX_EN_TIME = `WBSR_TX_EN_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  input wire soft_rst,
  input wire restart,
  // register port
  input wire [6:0] reg_addr,
  input wire reg_rd,
  input wire reg_clr,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // second LIN transceiver
  input wire lin2_active,
  input wire lin2_tx_in,
  input wire lin2_bus_recessive,
  input wire lin2_thermal_shutdown,
  input wire lin2_supply_ok,
  output reg lin2_tx_enable,
  // wake events, one-cycle pulses
  input wire [6:0] wake_event_main,
  input wire [1:0] wake_event_gpio,
  input wire failsafe_wake,
  input wire [8:0] failsafe_wake_src,
  // pin levels and modes
  input wire [2:0] wake_in_pin,
  input wire [1:0] gpio_pin,
  input wire [1:0] gpio_selected,
  input wire [1:0] gpio_level_cfg,
  input wire mode_normal_stop,
  input wire cyclic_sense,
  input wire sample_strobe,
  input wire test_fail_output_pin,
  input wire int_pullup_strap,
  // debug copies of the status registers
  output reg [1:0] second_lin_fault_code,
  output reg [7:0] wake_flags_out
);

  reg [7:0] lin_second_fault_status;
  reg [7:0] wake_source_flags_main;
  reg [7:0] wake_source_flags_gpio;
  reg [7:0] wake_input_levels;
  reg strap_taken;
  reg [7:0] next_wake_main;
  reg [7:0] next_wake_gpio;
  reg [7:0] set_main;
  reg [7:0] set_gpio;
  reg [7:0] rd_mux;
  wire flt_event;
  wire [1:0] flt_code;
  wire flt_tx_enable;
  wire clr_fault;
  wire clr_main;
  wire clr_gpio;
  wire any_rst;

  assign any_rst = sys_rst || soft_rst;
  assign clr_fault = reg_clr && (reg_addr == `WBSR_ADDR_LIN_FAULT);
  assign clr_main = reg_clr && (reg_addr == `WBSR_ADDR_WAKE_MAIN);
  assign clr_gpio = reg_clr && (reg_addr == `WBSR_ADDR_WAKE_GPIO);

  wbsr_lin_fault #(
    .CNT_W(CNT_W),
    .DOM_TIMEOUT(DOM_TIMEOUT),
    .TX_EN_TIME(TX_EN_TIME)
  ) u_lin_fault (
    .sys_clk(sys_clk),
    .sys_rst(any_rst),
    .trx_active(lin2_active),
    .tx_in(lin2_tx_in),
    .bus_recessive(lin2_bus_recessive),
    .thermal_shutdown(lin2_thermal_shutdown),
    .supply_ok(lin2_supply_ok),
    .fault_event(flt_event),
    .fault_code(flt_code),
    .tx_enable(flt_tx_enable)
  );

  // wake set vectors, live event or fail-safe exit source
  always @* begin
    set_main = 8'h00;
    set_gpio = 8'h00;
    set_main[`WBSR_WK_IN1] = wake_event_main[0] || (failsafe_wake && failsafe_wake_src[0]);
    set_main[`WBSR_WK_IN2] = wake_event_main[1] || (failsafe_wake && failsafe_wake_src[1]);
    set_main[`WBSR_WK_IN3] = wake_event_main[2] || (failsafe_wake && failsafe_wake_src[2]);
    set_main[`WBSR_WK_TIMER] = wake_event_main[3] || (failsafe_wake && failsafe_wake_src[3]);
    set_main[`WBSR_WK_CAN] = wake_event_main[4] || (failsafe_wake && failsafe_wake_src[4]);
    set_main[`WBSR_WK_LIN1] = wake_event_main[5] || (failsafe_wake && failsafe_wake_src[5]);
    set_main[`WBSR_WK_LIN2] = wake_event_main[6] || (failsafe_wake && failsafe_wake_src[6]);
    set_gpio[`WBSR_WK_GPIO1] = wake_event_gpio[0] || (failsafe_wake && failsafe_wake_src[7]);
    set_gpio[`WBSR_WK_GPIO2] = wake_event_gpio[1] || (failsafe_wake && failsafe_wake_src[8]);
  end

  // sticky flags, set wins over a clear in the same cycle
  always @* begin
    next_wake_main = ((clr_main ? 8'h00 : wake_source_flags_main) | set_main) & `WBSR_MASK_WAKE_MAIN;
    next_wake_gpio = ((clr_gpio ? 8'h00 : wake_source_flags_gpio) | set_gpio) & `WBSR_MASK_WAKE_GPIO;
  end

  // fault register
  always @(posedge sys_clk) begin
    if (any_rst) begin
      lin_second_fault_status <= `WBSR_RST_LIN_FAULT;
    end else if (restart) begin
      lin_second_fault_status <= lin_second_fault_status & `WBSR_MASK_LIN_FAULT;
    end else if (flt_event) begin
      lin_second_fault_status <= {5'h00, flt_code, 1'b0};
    end else if (clr_fault) begin
      lin_second_fault_status <= `WBSR_RST_LIN_FAULT;
    end
  end

  // wake flag registers, restart keeps their contents
  always @(posedge sys_clk) begin
    if (any_rst) begin
      wake_source_flags_main <= `WBSR_RST_WAKE_MAIN;
      wake_source_flags_gpio <= `WBSR_RST_WAKE_GPIO;
    end else begin
      wake_source_flags_main <= next_wake_main;
      wake_source_flags_gpio <= next_wake_gpio;
    end
  end

  // level register
  always @(posedge sys_clk) begin
    if (any_rst) begin
      wake_input_levels <= `WBSR_RST_LEVELS;
      strap_taken <= 1'b0;
    end else begin
      // configuration strap caught once after reset release
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        wake_input_levels[`WBSR_LVL_INTERRUPT_PULLUP_CONFIG_STATUS] <= int_pullup_strap;
      end
      wake_input_levels[`WBSR_LVL_DEV] <= test_fail_output_pin;
      // wake inputs: live, or the latest sample in cyclic sense
      if (!cyclic_sense || sample_strobe)
        wake_input_levels[2:0] <= wake_in_pin;
      wake_input_levels[3] <= 1'b0;
      // gpios follow the pin directly, never the cyclic sample
      if (gpio_selected[0] && (!gpio_level_cfg[0] || mode_normal_stop))
        wake_input_levels[`WBSR_LVL_GPIO1] <= gpio_pin[0];
      if (gpio_selected[1] && (!gpio_level_cfg[1] || mode_normal_stop))
        wake_input_levels[`WBSR_LVL_GPIO2] <= gpio_pin[1];
    end
  end

  // read decode
  always @* begin
    if (reg_addr == `WBSR_ADDR_LIN_FAULT)
      rd_mux = lin_second_fault_status & `WBSR_MASK_LIN_FAULT;
    else if (reg_addr == `WBSR_ADDR_WAKE_MAIN)
      rd_mux = wake_source_flags_main & `WBSR_MASK_WAKE_MAIN;
    else if (reg_addr == `WBSR_ADDR_WAKE_GPIO)
      rd_mux = wake_source_flags_gpio & `WBSR_MASK_WAKE_GPIO;
    else if (reg_addr == `WBSR_ADDR_LEVELS)
      rd_mux = wake_input_levels & `WBSR_MASK_LEVELS;
    else
      rd_mux = 8'h00;
  end

  // registered outputs
  always @(posedge sys_clk) begin
    if (any_rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      lin2_tx_enable <= 1'b0;
      second_lin_fault_code <= `WBSR_CODE_NONE;
      wake_flags_out <= 8'h00;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
      lin2_tx_enable <= flt_tx_enable;
      second_lin_fault_code <= lin_second_fault_status[`WBSR_FAULT_HI:`WBSR_FAULT_LO];
      wake_flags_out <= wake_source_flags_main;
    end
  end

endmodule // wbsr_top

// >>> tb/wbsr_asserts.sv
`timescale 1ns/1ps
`include "wbsr_regs.vh"
module wbsr_asserts #(
  parameter int TX_EN_TIME = 200
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  input wire soft_rst,
  // register port
  input wire [6:0] reg_addr,
  input wire reg_clr,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  // transceiver
  input wire lin2_active,
  input wire lin2_tx_in,
  input wire lin2_supply_ok,
  input wire lin2_tx_enable,
  // wake
  input wire [6:0] wake_event_main,
  input wire [7:0] wake_flags_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || soft_rst);
  // run length of transmit input high
  logic [31:0] hi_cnt;
  wire [7:0] ev_flags = {wake_event_main[6:3], 1'b0, wake_event_main[2:0]};
  always @(posedge sys_clk) begin
    if (sys_rst || !lin2_tx_in) begin
      hi_cnt <= 32'h0;
    end else if (hi_cnt != 32'hFFFFFFFF) begin
      hi_cnt <= hi_cnt + 32'h1;
    end
  end
  a_fault_reserved: assert property (reg_rvalid && $past(reg_addr) == `WBSR_ADDR_LIN_FAULT
    |-> (reg_rdata & ~`WBSR_MASK_LIN_FAULT) == 8'h00) else $error("fault reg reserved bits set");
  a_wake_reserved: assert property (reg_rvalid && $past(reg_addr) == `WBSR_ADDR_WAKE_GPIO
    |-> (reg_rdata & ~`WBSR_MASK_WAKE_GPIO) == 8'h00) else $error("gpio wake reserved bits set");
  a_level_reserved: assert property (reg_rvalid && $past(reg_addr) == `WBSR_ADDR_LEVELS
    |-> reg_rdata[3] == 1'b0) else $error("level reserved bit set");
  a_unmapped_zero: assert property (reg_rvalid && ($past(reg_addr) < 7'h45 || $past(reg_addr) > 7'h48)
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_tx_en_wait: assert property ($rose(lin2_tx_enable) |-> hi_cnt >= TX_EN_TIME)
    else $error("transmitter enabled too early");
  a_tx_off_idle: assert property (!lin2_active |-> ##[0:2] !lin2_tx_enable)
    else $error("transmitter on while inactive");
  a_tx_off_uv: assert property (!lin2_supply_ok |-> ##[0:2] !lin2_tx_enable)
    else $error("transmitter on during undervoltage");
  a_flag_held: assert property (|($past(wake_flags_out) & ~wake_flags_out) |->
    $past(sys_rst || soft_rst) || ($past(reg_clr, 2) && $past(reg_addr, 2) == `WBSR_ADDR_WAKE_MAIN))
    else $error("wake flag lost");
  a_flag_set: assert property (wake_event_main != 7'h00 ##1 !reg_clr ##1 !reg_clr
    |=> (wake_flags_out & $past(ev_flags, 3)) == $past(ev_flags, 3)) else $error("wake flag not set");
endmodule // wbsr_asserts

// >>> tb/tb_wbsr_top.sv
`timescale 1ns/1ps
`include "wbsr_regs.vh"
module tb_wbsr_top;
  localparam int DOM = 20;
  localparam int TXE = 5;
  logic sys_clk = 0, sys_rst = 1, soft_rst = 0, restart = 0, reg_rd = 0, reg_clr = 0;
  logic [6:0] reg_addr = 0, wake_event_main = 0;
  logic lin2_active = 1, lin2_tx_in = 1, lin2_bus_recessive = 1, lin2_thermal_shutdown = 0, lin2_supply_ok = 1;
  logic [1:0] wake_event_gpio = 0, gpio_pin = 0, gpio_selected = 2'h3, gpio_level_cfg = 0, gp_old;
  logic failsafe_wake = 0, mode_normal_stop = 0, cyclic_sense = 0, sample_strobe = 0;
  logic [8:0] failsafe_wake_src = 0;
  logic [2:0] wake_in_pin = 0, wk_old;
  logic test_fail_output_pin = 0, int_pullup_strap = 1;
  wire [7:0] reg_rdata, wake_flags_out;
  wire [1:0] second_lin_fault_code;
  wire reg_rvalid, lin2_tx_enable;
  logic [31:0] seed = 32'd55;
  logic [7:0] em = 0, eg = 0;
  int num_errors = 0, checks_done = 0, cycles = 0;
  wbsr_top #(.DOM_TIMEOUT(20'd20), .TX_EN_TIME(20'd5)) wbsr_top_i (.sys_clk, .sys_rst, .soft_rst, .restart,
    .reg_addr, .reg_rd, .reg_clr, .reg_rdata, .reg_rvalid, .lin2_active, .lin2_tx_in, .lin2_bus_recessive,
    .lin2_thermal_shutdown, .lin2_supply_ok, .lin2_tx_enable, .wake_event_main, .wake_event_gpio,
    .failsafe_wake, .failsafe_wake_src, .wake_in_pin, .gpio_pin, .gpio_selected, .gpio_level_cfg,
    .mode_normal_stop, .cyclic_sense, .sample_strobe, .test_fail_output_pin, .int_pullup_strap,
    .second_lin_fault_code, .wake_flags_out);
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors = num_errors + 1;
      results();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [7:0] fmap(input logic [6:0] e);
    return {e[6:3], 1'b0, e[2:0]};
  endfunction
  function automatic logic [7:0] lvl(input logic d, input logic [1:0] g, input logic [2:0] w);
    return {d, 1'b1, g, 1'b0, w};
  endfunction
  task automatic ck(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge sys_clk);
    reg_rd = 0;
    ck("rvalid", {7'h00, reg_rvalid}, 8'h01);
    ck("rdata", reg_rdata, exp);
  endtask
  task automatic clr(input logic [6:0] a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_clr = 1;
    @(negedge sys_clk);
    reg_clr = 0;
  endtask
  task automatic txen(input logic e);
    ck("tx_enable", {7'h00, lin2_tx_enable}, {7'h00, e});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(6);
    sys_rst = 0;
    cyc(3);
    for (int i = 0; i < 8; i++) rd(7'h45 + i, (i == 3) ? lvl(0, 0, 0) : 8'h00);
    txen(1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {int_pullup_strap, test_fail_output_pin, gpio_pin, wake_in_pin} = seed[6:0];
      cyc(3);
      rd(7'h48, lvl(seed[5], seed[4:3], seed[2:0]));
    end
    cyclic_sense = 1;
    wk_old = wake_in_pin;
    wake_in_pin = ~wk_old;
    gpio_pin = ~gpio_pin;
    cyc(3);
    rd(7'h48, lvl(test_fail_output_pin, gpio_pin, wk_old));
    sample_strobe = 1;
    cyc(1);
    sample_strobe = 0;
    cyc(2);
    rd(7'h48, lvl(test_fail_output_pin, gpio_pin, wake_in_pin));
    {cyclic_sense, gpio_level_cfg, gp_old} = {3'b011, gpio_pin};
    gpio_pin = ~gp_old;
    cyc(3);
    rd(7'h48, lvl(test_fail_output_pin, gp_old, wake_in_pin));
    mode_normal_stop = 1;
    cyc(3);
    rd(7'h48, lvl(test_fail_output_pin, gpio_pin, wake_in_pin));
    {gpio_selected, gp_old} = {2'h0, gpio_pin};
    gpio_pin = ~gp_old;
    cyc(3);
    rd(7'h48, lvl(test_fail_output_pin, gp_old, wake_in_pin));
    gpio_selected = 2'h3;
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      if (seed[19]) {failsafe_wake, failsafe_wake_src} = {1'b1, seed[18:10]};
      else {wake_event_gpio, wake_event_main} = seed[8:0];
      em |= seed[19] ? fmap(seed[16:10]) : fmap(seed[6:0]);
      eg |= {2'b00, seed[19] ? seed[18:17] : seed[8:7], 4'h0};
      cyc(1);
      {failsafe_wake, wake_event_gpio, wake_event_main} = 0;
      rd(7'h46, em);
      rd(7'h47, eg);
      if (seed[20]) clr(7'h46);
      if (seed[20]) em = 0;
      if (seed[21]) clr(7'h47);
      if (seed[21]) eg = 0;
    end
    {reg_addr, reg_clr, wake_event_main} = {7'h46, 1'b1, 7'h01};
    cyc(1);
    {reg_clr, wake_event_main} = 0;
    rd(7'h46, 8'h01);
    ck("wake_flags_out", wake_flags_out, 8'h01);
    lin2_tx_in = 0;
    cyc(DOM + 4);
    rd(7'h45, 8'h04);
    ck("fault_code", {6'h00, second_lin_fault_code}, 8'h02);
    txen(0);
    lin2_tx_in = 1;
    cyc(TXE - 2);
    txen(0);
    cyc(TXE + 2);
    txen(1);
    restart = 1;
    cyc(1);
    restart = 0;
    rd(7'h45, 8'h04);
    rd(7'h46, 8'h01);
    clr(7'h45);
    rd(7'h45, 8'h00);
    lin2_bus_recessive = 0;
    cyc(DOM + 4);
    rd(7'h45, 8'h06);
    ck("fault_code", {6'h00, second_lin_fault_code}, 8'h03);
    txen(0);
    lin2_bus_recessive = 1;
    cyc(TXE + 4);
    txen(1);
    lin2_thermal_shutdown = 1;
    cyc(3);
    rd(7'h45, 8'h02);
    ck("fault_code", {6'h00, second_lin_fault_code}, 8'h01);
    txen(0);
    lin2_thermal_shutdown = 0;
    cyc(TXE + 4);
    txen(1);
    for (int i = 0; i < 2; i++) begin
      {lin2_active, lin2_supply_ok} = i ? 2'b10 : 2'b01;
      cyc(3);
      txen(0);
      {lin2_active, lin2_supply_ok} = 2'b11;
      cyc(TXE + 4);
      txen(1);
    end
    int_pullup_strap = 0;
    soft_rst = 1;
    cyc(1);
    soft_rst = 0;
    cyc(2);
    rd(7'h45, 8'h00);
    rd(7'h46, 8'h00);
    rd(7'h48, lvl(test_fail_output_pin, gpio_pin, wake_in_pin) & 8'hBF);
    results();
  end
endmodule // tb_wbsr_top
bind wbsr_top wbsr_asserts #(.TX_EN_TIME(TX_EN_TIME)) wbsr_asserts_i (.sys_clk, .sys_rst, .soft_rst, .reg_addr,
  .reg_clr, .reg_rdata, .reg_rvalid, .lin2_active, .lin2_tx_in, .lin2_supply_ok, .lin2_tx_enable,
  .wake_event_main, .wake_flags_out);
